// file: core/ovsr_pkg.sv
// Shared constants, types and encodings of the output voltage setpoint register bank
package ovsr_pkg;

  // Command codes of the setpoint bank
  localparam logic [7:0] FORMAT_CODE = 8'h20;
  localparam logic [7:0] SETPOINT_CODE = 8'h21;
  localparam logic [7:0] OFFSET_CODE = 8'h22;
  localparam logic [7:0] CEILING_CODE = 8'h24;
  localparam logic [7:0] UPPER_CODE = 8'h25;
  localparam logic [7:0] LOWER_CODE = 8'h26;
  localparam logic [7:0] SLEW_CODE = 8'h27;

  // Reset values loaded as the stored defaults
  localparam logic [15:0] SETPOINT_RESET = 16'h0133;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] CEILING_RESET = 16'h1c00;
  localparam logic [15:0] UPPER_RESET = 16'h0142;
  localparam logic [15:0] LOWER_RESET = 16'h0123;
  localparam logic [15:0] SLEW_RESET = 16'he002;

  // Read-only format byte: mode field and exponent field
  localparam int FORMAT_MODE_POS = 5;
  localparam int FORMAT_EXP_POS = 0;
  localparam logic [2:0] FORMAT_MODE_UNSIGNED = 3'h0;
  localparam logic [4:0] FORMAT_EXP = 5'h17;
  localparam logic [7:0] FORMAT_BYTE = 8'h17;

  // Slew word layout: exponent 15:11, mantissa 10:0
  localparam int SLEW_EXP_MSB = 15;
  localparam int SLEW_EXP_LSB = 11;
  localparam int SLEW_MAN_MSB = 10;
  localparam logic [4:0] SLEW_EXP = 5'h1c;
  localparam logic [10:0] SLEW_MAN_MIN = 11'h001;
  localparam logic [10:0] SLEW_MAN_MAX = 11'h020;

  // Ramp timing: rate step and setpoint step in nV, clock in MHz
  localparam int RATE_UNIT_NV = 62500;
  localparam int SETPOINT_LSB_NV = 1953125;
  localparam int CLK_MHZ = 25;
  localparam logic [31:0] RAMP_THRESH = 32'(SETPOINT_LSB_NV * CLK_MHZ);
  localparam logic [31:0] RATE_UNIT = 32'(RATE_UNIT_NV);

  // Width of the trim shift; the highest shift of 3 gives a scale factor of one eighth
  localparam int TRIM_SHIFT_W = 2;

  // Operation control selection of the target source
  typedef enum logic [1:0] {
    OVSR_OP_NOMINAL,
    OVSR_OP_MARGIN_HIGH,
    OVSR_OP_MARGIN_LOW
  } ovsr_op_t;

  // Ramp direction state
  typedef enum logic [1:0] {
    OVSR_RAMP_IDLE,
    OVSR_RAMP_UP,
    OVSR_RAMP_DOWN
  } ovsr_ramp_t;

  // Command from the bus decoder
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } ovsr_cmd_t;

  // Answer to a command
  typedef struct packed {
    logic err;
    logic [15:0] data;
  } ovsr_rsp_t;

endpackage

// file: core/ovsr_target.sv
// Effective target: selected setpoint plus scaled trim, clamped to the ceiling
`timescale 1ns/1ns
module ovsr_target
  import ovsr_pkg::*;
(
  input wire logic [15:0] baseWord,
  input wire logic [15:0] offsetWord,
  input wire logic [TRIM_SHIFT_W-1:0] trimShift,
  input wire logic [15:0] ceilingWord,
  output logic [15:0] effWord,
  output logic ceilingHit
);

  logic signed [20:0] trimScaled;
  logic signed [20:0] sum;

  // Trim divided by the scale factor is a left shift
  // trim offset added
  always_comb begin
    trimScaled = signed'({{5{offsetWord[15]}}, offsetWord}) <<< trimShift;
    sum = signed'({5'h00, baseWord}) + trimScaled;
  end

  // Floor at zero, then ceiling clamp
  // never above ceiling
  always_comb begin
    ceilingHit = 1'b0;
    if (sum < 0) begin
      effWord = 16'h0000;
    end else if (sum > signed'({5'h00, ceilingWord})) begin
      effWord = ceilingWord;
      ceilingHit = 1'b1;
    end else begin
      effWord = sum[15:0];
    end
  end

endmodule

// file: core/ovsr_ramp.sv
// Slewed output word that walks toward the target at the programmed rate
`timescale 1ns/1ns
module ovsr_ramp
  import ovsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] target,
  input wire logic [10:0] rateMan,
  input wire logic follow,
  output logic [15:0] level_r,
  output logic busy_r
);

  ovsr_ramp_t state_r;
  ovsr_ramp_t state_nxt;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic stepDue;

  // Phase accumulator sum and step decision
  always_comb begin
    acc_nxt = acc_r + 32'(rateMan) * RATE_UNIT;
    stepDue = (acc_nxt >= RAMP_THRESH);
  end

  // Direction from the target comparison
  always_comb begin
    if (follow || level_r == target) begin
      state_nxt = OVSR_RAMP_IDLE;
    end else if (target > level_r) begin
      state_nxt = OVSR_RAMP_UP;
    end else begin
      state_nxt = OVSR_RAMP_DOWN;
    end
  end

  // Direction state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= OVSR_RAMP_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Accumulator is cleared whenever no ramp runs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_r <= 32'h0000_0000;
    end else if (ce) begin
      if (state_r == OVSR_RAMP_IDLE || state_nxt != state_r) begin
        acc_r <= 32'h0000_0000;
      end else if (stepDue) begin
        acc_r <= acc_nxt - RAMP_THRESH;
      end else begin
        acc_r <= acc_nxt;
      end
    end
  end

  // Output level: jumps while not converting, otherwise steps one code at a time
  // ramp at slew rate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level_r <= SETPOINT_RESET;
    end else if (ce) begin
      case (state_r)
        OVSR_RAMP_IDLE: begin
          if (follow) begin
            level_r <= target;
          end
        end
        OVSR_RAMP_UP: begin
          if (follow) begin
            level_r <= target;
          end else if (stepDue && state_nxt == OVSR_RAMP_UP) begin
            level_r <= level_r + 16'h0001;
          end
        end
        OVSR_RAMP_DOWN: begin
          if (follow) begin
            level_r <= target;
          end else if (stepDue && state_nxt == OVSR_RAMP_DOWN) begin
            level_r <= level_r - 16'h0001;
          end
        end
        default: begin
          level_r <= target;
        end
      endcase
    end
  end

  // Busy while converting and the level differs from the target
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= (state_nxt != OVSR_RAMP_IDLE);
    end
  end

endmodule

// file: core/ovsr_regs.sv
// Output voltage setpoint register bank with target selection, clamp and slew
//
// Summary of operation
// - Nominal setpoint: 16-bit unsigned read/write word
// - Nominal setpoint resets to 0133h
// - Setpoint range 0.3-14 V, 1.953 mV
// - Trim word, shifted by scale, added
// - Trim spans +-2 V, resets zero
// - Effective target never above ceiling word
// - Ceiling word read/write, resets 1C00h
// - Margin high selects upper margin word
// - Margin low selects lower margin word
// - Target changes ramp at slew rate while converting
// - Slew word: exponent 11100, signed mantissa
// - Slew 1 to 32 steps, reset E002h
// - Bad slew write ignored and reported
// - Format byte read-only, exponent -9
`timescale 1ns/1ns
module ovsr_regs
  import ovsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmdValid,
  input wire ovsr_cmd_t cmd,
  input wire ovsr_op_t opSelect,
  input wire logic [TRIM_SHIFT_W-1:0] trimShift,
  input wire logic convOn,
  input wire logic faultClear,
  output logic rspValid_r,
  output ovsr_rsp_t rsp_r,
  output logic [15:0] effTarget_r,
  output logic [15:0] outLevel_r,
  output logic rampBusy_r,
  output logic ceilingHit_r,
  output logic rateRejected_r,
  output logic rejectPulse_r
);

  // Returns true for a write of the given code
  function automatic logic isWrite(input logic valid, input ovsr_cmd_t c,
                                   input logic [7:0] code);
    isWrite = valid && c.write && (c.code == code);
  endfunction

  // Valid slew word: fixed exponent, positive mantissa in range
  function automatic logic slewOk(input logic [15:0] w);
    logic [10:0] scale_mantissa_field;
    scale_mantissa_field = w[SLEW_MAN_MSB:0];
    slewOk = (w[SLEW_EXP_MSB:SLEW_EXP_LSB] == SLEW_EXP) &&
             (scale_mantissa_field >= SLEW_MAN_MIN) && (scale_mantissa_field <= SLEW_MAN_MAX);
  endfunction

  // Known command code check
  function automatic logic isKnown(input logic [7:0] code);
    case (code)
      FORMAT_CODE, SETPOINT_CODE, OFFSET_CODE, CEILING_CODE,
      UPPER_CODE, LOWER_CODE, SLEW_CODE: isKnown = 1'b1;
      default: isKnown = 1'b0;
    endcase
  endfunction

  logic [15:0] setpoint_r;
  logic [15:0] offset_r;
  logic [15:0] ceiling_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] slew_r;
  logic [15:0] baseWord;
  logic [15:0] effWord;
  logic ceilingHit;
  logic slewWrite;
  logic slewBad;
  logic [15:0] readWord;
  logic readErr;
  logic [15:0] rampLevel;
  logic rampBusy;

  // Nominal setpoint word
  // setpoint storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      setpoint_r <= SETPOINT_RESET;
    end else if (ce && isWrite(cmdValid, cmd, SETPOINT_CODE)) begin
      setpoint_r <= cmd.data;
    end
  end

  // Signed trim word, written as the host computed it
  // trim default zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      offset_r <= OFFSET_RESET;
    end else if (ce && isWrite(cmdValid, cmd, OFFSET_CODE)) begin
      offset_r <= cmd.data;
    end
  end

  // Ceiling word
  // ceiling storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ceiling_r <= CEILING_RESET;
    end else if (ce && isWrite(cmdValid, cmd, CEILING_CODE)) begin
      ceiling_r <= cmd.data;
    end
  end

  // Upper margin setpoint
  // upper margin storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      upper_r <= UPPER_RESET;
    end else if (ce && isWrite(cmdValid, cmd, UPPER_CODE)) begin
      upper_r <= cmd.data;
    end
  end

  // Lower margin setpoint
  // lower margin storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lower_r <= LOWER_RESET;
    end else if (ce && isWrite(cmdValid, cmd, LOWER_CODE)) begin
      lower_r <= cmd.data;
    end
  end

  // Slew write qualification
  // exponent and mantissa check
  always_comb begin
    slewWrite = isWrite(cmdValid, cmd, SLEW_CODE);
    slewBad = slewWrite && !slewOk(cmd.data);
  end

  // Slew word keeps its old value on a bad write
  // slew default and range
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slew_r <= SLEW_RESET;
    end else if (ce && slewWrite && !slewBad) begin
      slew_r <= cmd.data;
    end
  end

  // Sticky rejection flag; a new rejection wins over a clear
  // report rejection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rateRejected_r <= 1'b0;
    end else if (ce) begin
      if (slewBad) begin
        rateRejected_r <= 1'b1;
      end else if (faultClear) begin
        rateRejected_r <= 1'b0;
      end
    end
  end

  // One-cycle rejection pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rejectPulse_r <= 1'b0;
    end else if (ce) begin
      rejectPulse_r <= slewBad;
    end
  end

  // Read data mux; the format byte sits in the low bits
  // fixed format byte
  always_comb begin
    readErr = 1'b0;
    case (cmd.code)
      FORMAT_CODE: readWord = {8'h00, FORMAT_BYTE};
      SETPOINT_CODE: readWord = setpoint_r;
      OFFSET_CODE: readWord = offset_r;
      CEILING_CODE: readWord = ceiling_r;
      UPPER_CODE: readWord = upper_r;
      LOWER_CODE: readWord = lower_r;
      SLEW_CODE: readWord = slew_r;
      default: begin
        readWord = 16'h0000;
        readErr = 1'b1;
      end
    endcase
  end

  // Answer one cycle after each command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rspValid_r <= 1'b0;
    end else if (ce) begin
      rspValid_r <= cmdValid;
    end
  end

  // Answer payload: error on unknown code, format write or bad slew
  // format byte not writable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_r <= '0;
    end else if (ce && cmdValid) begin
      if (cmd.write) begin
        rsp_r.data <= 16'h0000;
        rsp_r.err <= !isKnown(cmd.code) || (cmd.code == FORMAT_CODE) || slewBad;
      end else begin
        rsp_r.data <= readWord;
        rsp_r.err <= readErr;
      end
    end
  end

  // Source selection by operation control
  // margin high source
  always_comb begin
    case (opSelect)
      OVSR_OP_MARGIN_HIGH: baseWord = upper_r;
      OVSR_OP_MARGIN_LOW: baseWord = lower_r;
      default: baseWord = setpoint_r;
    endcase
  end

  // Trim and ceiling arithmetic
  ovsr_target u_target (
    .baseWord(baseWord),
    .offsetWord(offset_r),
    .trimShift(trimShift),
    .ceilingWord(ceiling_r),
    .effWord(effWord),
    .ceilingHit(ceilingHit)
  );

  // Registered effective target and clamp indication
  // clamped target registered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      effTarget_r <= SETPOINT_RESET;
      ceilingHit_r <= 1'b0;
    end else if (ce) begin
      effTarget_r <= effWord;
      ceilingHit_r <= ceilingHit;
    end
  end

  // Ramp toward the target; jumps while conversion is off
  // no slew on turn-on or off
  ovsr_ramp u_ramp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .target(effTarget_r),
    .rateMan(slew_r[SLEW_MAN_MSB:0]),
    .follow(!convOn),
    .level_r(rampLevel),
    .busy_r(rampBusy)
  );

  // Output copies of the ramp state
  always_comb begin
    outLevel_r = rampLevel;
    rampBusy_r = rampBusy;
  end

endmodule

// file: sim/ovsr_regs_sva.sv
// Checker of the setpoint bank ports
`timescale 1ns/1ns
module ovsr_regs_sva
  import ovsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmdValid,
  input wire ovsr_cmd_t cmd,
  input wire logic convOn,
  input wire logic faultClear,
  input wire logic rspValid_r,
  input wire ovsr_rsp_t rsp_r,
  input wire logic [15:0] effTarget_r,
  input wire logic [15:0] outLevel_r,
  input wire logic ceilingHit_r,
  input wire logic rateRejected_r,
  input wire logic rejectPulse_r
);
  logic [15:0] ceilShadow_r;
  logic take;
  logic slewWr;
  logic slewBad;
  logic known;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Command decode seen from the ports
  assign take = cmdValid && ce;
  assign slewWr = take && cmd.write && cmd.code == SLEW_CODE;
  assign slewBad = cmd.data[15:11] != 5'h1c || cmd.data[10:0] < 11'h001
    || cmd.data[10:0] > 11'h020;
  assign known = cmd.code inside {8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27};
  // Shadow of the ceiling word
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ceilShadow_r <= 16'h1c00;
    end else if (take && cmd.write && cmd.code == CEILING_CODE) begin
      ceilShadow_r <= cmd.data;
    end
  end
  a_rsp_follows: assert property (take |=> rspValid_r)
    else $error("no answer after command");
  a_rsp_cause: assert property (rspValid_r |-> $past(take))
    else $error("answer without command");
  a_ceiling_bound: assert property (effTarget_r <= $past(ceilShadow_r))
    else $error("target above ceiling");
  a_hit_clamped: assert property (ceilingHit_r |-> effTarget_r == $past(ceilShadow_r))
    else $error("clamp flag without ceiling value");
  a_slew_reject: assert property (slewWr && slewBad |=>
    rejectPulse_r && rsp_r.err && rateRejected_r)
    else $error("bad slew write not refused");
  a_slew_accept: assert property (slewWr && !slewBad |=>
    !rejectPulse_r && rsp_r == {1'b0, 16'h0000})
    else $error("good slew write refused");
  a_pulse_cause: assert property (rejectPulse_r |-> $past(slewWr && slewBad))
    else $error("reject pulse without bad write");
  a_reject_sticky: assert property (rateRejected_r && !faultClear && ce |=>
    rateRejected_r)
    else $error("reject flag lost");
  a_format_read: assert property (take && cmd.code == FORMAT_CODE |=>
    rsp_r.err == $past(cmd.write) && rsp_r.data == ($past(cmd.write) ? 16'h0000 : 16'h0017))
    else $error("format byte wrong");
  a_code_unknown: assert property (take && !known |=> rsp_r == {1'b1, 16'h0000})
    else $error("unknown code accepted");
  a_ramp_step: assert property ($past(convOn) && $past(convOn, 2) |->
    16'(outLevel_r - $past(outLevel_r) + 16'h0001) <= 16'h0002)
    else $error("ramp jumped");
  a_direct_follow: assert property (!convOn ##1 !convOn |->
    outLevel_r == $past(effTarget_r))
    else $error("output not following target");
endmodule

bind ovsr_regs ovsr_regs_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
  .cmdValid(cmdValid), .cmd(cmd), .convOn(convOn), .faultClear(faultClear),
  .rspValid_r(rspValid_r), .rsp_r(rsp_r), .effTarget_r(effTarget_r),
  .outLevel_r(outLevel_r), .ceilingHit_r(ceilingHit_r),
  .rateRejected_r(rateRejected_r), .rejectPulse_r(rejectPulse_r));

// file: sim/ovsr_host_model.sv
// Host model issuing single register commands
`timescale 1ns/1ns
module ovsr_host_model
  import ovsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rspValid_r,
  input wire ovsr_rsp_t rsp_r,
  output logic cmdValid,
  output ovsr_cmd_t cmd
);
  // Idle bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // One command; answer taken one cycle later
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
      output ovsr_rsp_t rsp, output logic ok);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmd <= {wr, code, data};
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    // Released bus shows the inverse, not the last value
    cmd <= ~cmd;
    #1;
    ok = rspValid_r;
    rsp = rsp_r;
  endtask
  task automatic trimWrite(input logic [15:0] factory, input logic [15:0] delta,
      output ovsr_rsp_t rsp, output logic ok);
    xfer(1'b1, OFFSET_CODE, 16'(factory + delta), rsp, ok);
  endtask
endmodule

// file: sim/tb_ovsr_regs.sv
// Testbench of the setpoint register bank
`timescale 1ns/1ns
module tb_ovsr_regs
  import ovsr_pkg::*;
;
  localparam logic [15:0] FACTORY_TRIM = 16'h0000;
  logic sys_clk = 1'b0;
  logic rst_n;
  logic convOn;
  logic faultClear;
  logic ce;
  logic [15:0] held;
  ovsr_op_t opSelect;
  logic [1:0] trimShift;
  logic cmdValid;
  ovsr_cmd_t cmd;
  logic rspValid_r;
  ovsr_rsp_t rsp_r;
  logic [15:0] effTarget_r;
  logic [15:0] outLevel_r;
  logic rampBusy_r;
  logic ceilingHit_r;
  logic rateRejected_r;
  logic rejectPulse_r;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic [7:0] rcode [6] = '{8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27};
  logic [15:0] rval [6] = '{16'h0133, 16'h0000, 16'h1c00, 16'h0142, 16'h0123, 16'he002};
  logic [15:0] bad [4] = '{16'he000, 16'he021, 16'he7ff, 16'he802};
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  ovsr_host_model u_host (.sys_clk(sys_clk), .rspValid_r(rspValid_r), .rsp_r(rsp_r),
    .cmdValid(cmdValid), .cmd(cmd));
  ovsr_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid),
    .cmd(cmd), .opSelect(opSelect), .trimShift(trimShift), .convOn(convOn),
    .faultClear(faultClear), .rspValid_r(rspValid_r), .rsp_r(rsp_r),
    .effTarget_r(effTarget_r), .outLevel_r(outLevel_r), .rampBusy_r(rampBusy_r),
    .ceilingHit_r(ceilingHit_r), .rateRejected_r(rateRejected_r),
    .rejectPulse_r(rejectPulse_r));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // One access with expected answer
  task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] data,
      input logic [15:0] expData, input logic expErr);
    ovsr_rsp_t r;
    logic ok;
    u_host.xfer(wr, code, data, r, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(r.data, expData);
    chk({15'h0, r.err}, {15'h0, expErr});
  endtask
  task automatic trim(input logic [15:0] delta);
    ovsr_rsp_t r;
    logic ok;
    u_host.trimWrite(FACTORY_TRIM, delta, r, ok);
    chk({14'h0, ok, r.err}, 16'h0002);
  endtask
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    convOn = 1'b0;
    faultClear = 1'b0;
    ce = 1'b1;
    opSelect = OVSR_OP_NOMINAL;
    trimShift = 2'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) acc(1'b0, rcode[i], 16'h0, rval[i], 1'b0);
    acc(1'b0, 8'h20, 16'h0, 16'h0017, 1'b0);
    acc(1'b1, 8'h20, 16'h00ff, 16'h0, 1'b1);
    acc(1'b1, 8'h23, 16'h1234, 16'h0, 1'b1);
    acc(1'b1, 8'h21, 16'h0200, 16'h0, 1'b0);
    acc(1'b0, 8'h21, 16'h0, 16'h0200, 1'b0);
    tick(3);
    chk(effTarget_r, 16'h0200);
    trim(16'h0010);
    trimShift <= 2'h1;
    tick(3);
    chk(effTarget_r, 16'h0220);
    trimShift <= 2'h0;
    trim(16'hfff0);
    acc(1'b0, 8'h22, 16'h0, 16'hfff0, 1'b0);
    tick(3);
    chk(effTarget_r, 16'h01f0);
    trim(16'h0000);
    opSelect <= OVSR_OP_MARGIN_HIGH;
    tick(3);
    chk(effTarget_r, 16'h0142);
    opSelect <= OVSR_OP_MARGIN_LOW;
    tick(3);
    chk(effTarget_r, 16'h0123);
    opSelect <= OVSR_OP_NOMINAL;
    acc(1'b1, 8'h24, 16'h0100, 16'h0, 1'b0);
    tick(3);
    chk(effTarget_r, 16'h0100);
    chk({15'h0, ceilingHit_r}, 16'h0001);
    acc(1'b0, 8'h21, 16'h0, 16'h0200, 1'b0);
    acc(1'b1, 8'h24, 16'h1c00, 16'h0, 1'b0);
    tick(3);
    chk({15'h0, ceilingHit_r}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h27, bad[i], 16'h0, 1'b1);
      chk({15'h0, rateRejected_r}, 16'h0001);
      chk({15'h0, rejectPulse_r}, 16'h0001);
      acc(1'b0, 8'h27, 16'h0, 16'he002, 1'b0);
    end
    faultClear <= 1'b1;
    tick(1);
    faultClear <= 1'b0;
    tick(2);
    chk({15'h0, rateRejected_r}, 16'h0000);
    acc(1'b1, 8'h27, 16'he020, 16'h0, 1'b0);
    chk({15'h0, rejectPulse_r}, 16'h0000);
    acc(1'b0, 8'h27, 16'h0, 16'he020, 1'b0);
    convOn <= 1'b1;
    tick(3);
    acc(1'b1, 8'h21, 16'h0204, 16'h0, 1'b0);
    tick(10);
    chk(outLevel_r, 16'h0200);
    chk({15'h0, rampBusy_r}, 16'h0001);
    for (n = 0; n < 300 && outLevel_r !== 16'h0204; n++) tick(1);
    chk(outLevel_r, 16'h0204);
    opSelect <= OVSR_OP_MARGIN_LOW;
    tick(200);
    // Clock enable low freezes the running ramp
    ce <= 1'b0;
    held = outLevel_r;
    tick(80);
    chk(outLevel_r, held);
    ce <= 1'b1;
    for (n = 0; n < 8000 && outLevel_r !== 16'h0123; n++) tick(1);
    chk(outLevel_r, 16'h0123);
    convOn <= 1'b0;
    opSelect <= OVSR_OP_NOMINAL;
    tick(4);
    chk(outLevel_r, 16'h0204);
    final_report();
  end
endmodule
